// >>> core/gppfm_pkg.sv
package gppfm_pkg;

  // ==========================================================
  // Register map, embedded controller local space
  // ==========================================================
  localparam int unsigned ADDR_W          = 16;
  localparam int unsigned DATA_W          = 8;
  localparam logic [15:0] FUNC_SEL1_ADDR  = 16'h7F3D;
  localparam logic [15:0] PASS_SEL_ADDR   = 16'h7F85;
  localparam logic [7:0]  FUNC_SEL1_RESET = 8'h00;
  localparam logic [7:0]  PASS_SEL_RESET  = 8'h00;
  // Writable bits; reserved bits stay zero and read as zero
  localparam logic [7:0]  FUNC_SEL1_WMASK = 8'hDF;
  localparam logic [7:0]  PASS_SEL_WMASK  = 8'h0F;
  localparam logic [7:0]  UNMAPPED_READ   = 8'h00;

  // ==========================================================
  // Field positions of pin_function_select_one
  // ==========================================================
  localparam int unsigned SERIAL_PINS_BIT = 7;
  localparam int unsigned GATE_BIT        = 6;
  localparam int unsigned PWM_ZERO_BIT    = 4;
  localparam int unsigned RX_LED_BIT      = 3;
  localparam int unsigned TX_LED_BIT      = 2;
  localparam int unsigned PS2_PINS_BIT    = 1;
  localparam int unsigned IRQ_PIN_BIT     = 0;

  // ==========================================================
  // Pass-through ports and levels
  // ==========================================================
  localparam int unsigned PASS_PAIRS      = 4;
  localparam int unsigned PASS_SEL_FIELDS = 4;
  localparam logic        LVL_LO          = 1'b0;
  localparam logic        LVL_HI          = 1'b1;
  localparam logic        DIR_OUT         = 1'b1;

  // Shared-pin routing chosen by (scan13_select, gate_select)
  typedef enum logic [1:0] {
    ROUTE_DEFAULT,
    ROUTE_GATE,
    ROUTE_SCAN13,
    ROUTE_BOTH
  } gppfm_route_e;

endpackage

// >>> core/gppfm_sync.sv
module gppfm_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  import gppfm_pkg::*;

  logic [W-1:0] meta_q;

  // Reset high: pins idle pulled up, so no false edge at release
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q   <= {W{LVL_HI}};
      sync_out <= {W{LVL_HI}};
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // gppfm_sync

// >>> core/gppfm_pass_pair.sv
module gppfm_pass_pair (
  input  wire logic sel,
  input  wire logic src_level,
  input  wire logic gpio_out,
  input  wire logic gpio_dir,
  output logic      pin_out,
  output logic      pin_oe
);
  import gppfm_pkg::*;

  // Own output logic is cut off entirely while passing through
  always_comb begin
    if (sel) begin
      pin_out = src_level;
      pin_oe  = LVL_HI;
    end else begin
      pin_out = gpio_out;
      pin_oe  = (gpio_dir == DIR_OUT);
    end
  end

endmodule // gppfm_pass_pair

// >>> core/gppfm_top.sv
module gppfm_top #(
  parameter int unsigned NUM_PAIRS = gppfm_pkg::PASS_PAIRS
) (
  input  wire logic                         clk,
  input  wire logic                         rst_b,
  input  wire logic [gppfm_pkg::ADDR_W-1:0] mcu_addr,
  input  wire logic                         mcu_wr_en,
  input  wire logic [gppfm_pkg::DATA_W-1:0] mcu_wr_data,
  input  wire logic                         mcu_rd_en,
  output logic      [gppfm_pkg::DATA_W-1:0] mcu_rd_data,
  input  wire logic                         scan13_select,
  input  wire logic [NUM_PAIRS-1:0]         source_pin,
  input  wire logic [NUM_PAIRS-1:0]         partner_gpio_out,
  input  wire logic [NUM_PAIRS-1:0]         partner_gpio_dir,
  output logic      [NUM_PAIRS-1:0]         partner_pin,
  output logic      [NUM_PAIRS-1:0]         partner_pin_oe,
  output logic      [NUM_PAIRS-1:0]         source_level,
  input  wire logic                         general_output_eight,
  input  wire logic                         keyboard_host_reset,
  input  wire logic                         addr_line_gate,
  input  wire logic                         scan_drive_twelve,
  input  wire logic                         scan_drive_thirteen,
  input  wire logic                         gpio17_out,
  input  wire logic                         gpio17_oe,
  input  wire logic                         gpio18_out,
  input  wire logic                         gpio18_oe,
  output logic                              general_output_eight_pin,
  output logic                              scan_drive_twelve_pin,
  output logic                              scan_drive_thirteen_pin,
  output logic                              scan_drive_thirteen_pin_oe,
  output logic                              gpio17_pin,
  output logic                              gpio17_pin_oe,
  input  wire logic                         gpio8_out,
  input  wire logic                         gpio8_oe,
  input  wire logic                         gpio9_out,
  input  wire logic                         gpio9_oe,
  input  wire logic                         uart_txd,
  input  wire logic                         gpio8_pin_in,
  output logic                              gpio8_pin,
  output logic                              gpio8_pin_oe,
  output logic                              gpio9_pin,
  output logic                              gpio9_pin_oe,
  output logic                              uart_rxd,
  input  wire logic                         general_output_ten,
  input  wire logic                         pwm_zero,
  output logic                              general_output_ten_pin,
  input  wire logic                         floppy_led_n,
  input  wire logic                         fdd_pin_in,
  output logic                              fdd_pin,
  output logic                              fdd_pin_oe,
  output logic                              mcu_serial_rx,
  input  wire logic                         power_led_n,
  input  wire logic                         mcu_serial_tx,
  output logic                              pwr_pin,
  input  wire logic                         general_output_one,
  input  wire logic                         irq_eight_n,
  output logic                              general_output_one_pin,
  input  wire logic                         gpio20_out,
  input  wire logic                         gpio20_oe,
  input  wire logic                         gpio21_out,
  input  wire logic                         gpio21_oe,
  input  wire logic                         ps2_chan_en,
  input  wire logic                         ps2_clk_drive_low,
  input  wire logic                         ps2_dat_drive_low,
  input  wire logic                         gpio20_pin_in,
  input  wire logic                         gpio21_pin_in,
  output logic                              gpio20_pin,
  output logic                              gpio20_pin_oe,
  output logic                              gpio21_pin,
  output logic                              gpio21_pin_oe,
  output logic                              ps2_pullup_en,
  output logic                              ps2_clk_in,
  output logic                              ps2_dat_in
);
  import gppfm_pkg::*;

  // ==========================================================
  // Elaboration checks
  // ==========================================================
  if (NUM_PAIRS < 1 || NUM_PAIRS > PASS_SEL_FIELDS) begin : g_chk
    $error("NUM_PAIRS must be 1 to 4");
  end

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic reg_hit(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] target
  );
    reg_hit = (addr == target);
  endfunction

  function automatic gppfm_route_e route_of(
    input logic scan13,
    input logic gate
  );
    gppfm_route_e r;
    r = ROUTE_DEFAULT;
    case ({scan13, gate})
      2'h0: r = ROUTE_DEFAULT;
      2'h1: r = ROUTE_GATE;
      2'h2: r = ROUTE_SCAN13;
      2'h3: r = ROUTE_BOTH;
      default: r = ROUTE_DEFAULT;
    endcase
    route_of = r;
  endfunction

  // ==========================================================
  // Register file
  // ==========================================================
  logic [DATA_W-1:0] pass_sel_q;
  logic [DATA_W-1:0] pass_sel_d;
  logic [DATA_W-1:0] func_sel_q;
  logic [DATA_W-1:0] func_sel_d;
  logic [DATA_W-1:0] rd_data_q;

  always_comb begin
    pass_sel_d = pass_sel_q;
    func_sel_d = func_sel_q;
    if (mcu_wr_en && reg_hit(mcu_addr, PASS_SEL_ADDR)) begin
      pass_sel_d = mcu_wr_data & PASS_SEL_WMASK;
    end
    if (mcu_wr_en && reg_hit(mcu_addr, FUNC_SEL1_ADDR)) begin
      func_sel_d = mcu_wr_data & FUNC_SEL1_WMASK;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pass_sel_q <= PASS_SEL_RESET;
      func_sel_q <= FUNC_SEL1_RESET;
    end else begin
      pass_sel_q <= pass_sel_d;
      func_sel_q <= func_sel_d;
    end
  end

  // Read returns the value held before a same-cycle write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_q <= UNMAPPED_READ;
    end else if (mcu_rd_en) begin
      if (reg_hit(mcu_addr, PASS_SEL_ADDR)) begin
        rd_data_q <= pass_sel_q;
      end else if (reg_hit(mcu_addr, FUNC_SEL1_ADDR)) begin
        rd_data_q <= func_sel_q;
      end else begin
        rd_data_q <= UNMAPPED_READ;
      end
    end
  end

  assign mcu_rd_data = rd_data_q;

  // ==========================================================
  // Pin input synchronisers
  // ==========================================================
  localparam int unsigned SYNC_W = NUM_PAIRS + 4;

  logic [SYNC_W-1:0] pins_sync;
  logic              gpio8_s;
  logic              fdd_s;
  logic              gpio20_s;
  logic              gpio21_s;

  gppfm_sync #(
    .W (SYNC_W)
  ) u_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in ({gpio21_pin_in, gpio20_pin_in, fdd_pin_in,
                gpio8_pin_in, source_pin}),
    .sync_out (pins_sync)
  );

  assign gpio8_s  = pins_sync[NUM_PAIRS];
  assign fdd_s    = pins_sync[NUM_PAIRS+1];
  assign gpio20_s = pins_sync[NUM_PAIRS+2];
  assign gpio21_s = pins_sync[NUM_PAIRS+3];
  // Source levels always reach interrupt and wake logic
  assign source_level = pins_sync[NUM_PAIRS-1:0];

  // ==========================================================
  // Pass-through pairs
  // ==========================================================
  // Sources are synchronised before they are forwarded, so a
  // partner follows its source two clocks plus one output flop late
  logic [NUM_PAIRS-1:0] part_d;
  logic [NUM_PAIRS-1:0] part_oe_d;
  logic [NUM_PAIRS-1:0] part_q;
  logic [NUM_PAIRS-1:0] part_oe_q;

  for (genvar i = 0; i < NUM_PAIRS; i++) begin : g_pair
    gppfm_pass_pair u_pair (
      .sel       (pass_sel_d[i]),
      .src_level (source_level[i]),
      .gpio_out  (partner_gpio_out[i]),
      .gpio_dir  (partner_gpio_dir[i]),
      .pin_out   (part_d[i]),
      .pin_oe    (part_oe_d[i])
    );
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      part_q    <= '0;
      part_oe_q <= '0;
    end else begin
      part_q    <= part_d;
      part_oe_q <= part_oe_d;
    end
  end

  assign partner_pin    = part_q;
  assign partner_pin_oe = part_oe_q;

  // ==========================================================
  // Function mux, built from next register values
  // ==========================================================
  // Scan pins also serve flash programming; that takeover lies
  // outside and overrides these outputs at the pad.
  gppfm_route_e route;
  logic         ps2_on;
  logic [23:0]  fn_d;
  logic [23:0]  fn_q;

  assign route  = route_of(scan13_select, func_sel_d[GATE_BIT]);
  assign ps2_on = func_sel_d[PS2_PINS_BIT];

  always_comb begin
    fn_d = '0;
    // Shared pins: output 8, scan 12, scan 13, pin 17
    case (route)
      ROUTE_DEFAULT: begin
        fn_d[0] = general_output_eight;
        fn_d[1] = scan_drive_twelve;
        fn_d[2] = scan_drive_thirteen;
        fn_d[3] = LVL_HI;
        fn_d[4] = gpio17_out;
        fn_d[5] = gpio17_oe;
      end
      ROUTE_GATE: begin
        fn_d[0] = keyboard_host_reset;
        fn_d[1] = scan_drive_twelve;
        fn_d[2] = scan_drive_thirteen;
        fn_d[3] = LVL_HI;
        fn_d[4] = addr_line_gate;
        fn_d[5] = LVL_HI;
      end
      ROUTE_SCAN13: begin
        fn_d[0] = general_output_eight;
        fn_d[1] = general_output_eight;
        fn_d[2] = gpio18_out;
        fn_d[3] = gpio18_oe;
        fn_d[4] = gpio17_out;
        fn_d[5] = gpio17_oe;
      end
      ROUTE_BOTH: begin
        fn_d[0] = keyboard_host_reset;
        fn_d[1] = keyboard_host_reset;
        fn_d[2] = gpio18_out;
        fn_d[3] = gpio18_oe;
        fn_d[4] = addr_line_gate;
        fn_d[5] = LVL_HI;
      end
      default: begin
        fn_d[0] = general_output_eight;
        fn_d[1] = scan_drive_twelve;
        fn_d[2] = scan_drive_thirteen;
        fn_d[3] = LVL_HI;
        fn_d[4] = gpio17_out;
        fn_d[5] = gpio17_oe;
      end
    endcase
    // Serial pins 8 and 9; idle receive line reads high
    if (func_sel_d[SERIAL_PINS_BIT]) begin
      fn_d[6]  = LVL_LO;
      fn_d[7]  = LVL_LO;
      fn_d[8]  = uart_txd;
      fn_d[9]  = LVL_HI;
      fn_d[10] = gpio8_s;
    end else begin
      fn_d[6]  = gpio8_out;
      fn_d[7]  = gpio8_oe;
      fn_d[8]  = gpio9_out;
      fn_d[9]  = gpio9_oe;
      fn_d[10] = LVL_HI;
    end
    fn_d[11] = func_sel_d[PWM_ZERO_BIT] ? pwm_zero
                                        : general_output_ten;
    if (func_sel_d[RX_LED_BIT]) begin
      fn_d[12] = LVL_LO;
      fn_d[13] = LVL_LO;
      fn_d[14] = fdd_s;
    end else begin
      fn_d[12] = floppy_led_n;
      fn_d[13] = LVL_HI;
      fn_d[14] = LVL_HI;
    end
    fn_d[15] = func_sel_d[TX_LED_BIT] ? mcu_serial_tx
                                      : power_led_n;
    fn_d[16] = func_sel_d[IRQ_PIN_BIT] ? irq_eight_n
                                       : general_output_one;
    // PS/2 pads are open drain: drive low or release
    if (ps2_on) begin
      fn_d[17] = LVL_LO;
      fn_d[18] = ps2_clk_drive_low;
      fn_d[19] = LVL_LO;
      fn_d[20] = ps2_dat_drive_low;
    end else begin
      fn_d[17] = gpio20_out;
      fn_d[18] = gpio20_oe;
      fn_d[19] = gpio21_out;
      fn_d[20] = gpio21_oe;
    end
    // Receive paths are shared between channels, so a channel
    // that is off must look idle high or it corrupts the other
    fn_d[21] = !(ps2_on && ps2_chan_en);
    fn_d[22] = (ps2_on && ps2_chan_en) ? gpio20_s : LVL_HI;
    fn_d[23] = (ps2_on && ps2_chan_en) ? gpio21_s : LVL_HI;
  end

  // Idle-high lines reset high so nothing sees a false start bit
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fn_q <= '0;
      fn_q[10] <= LVL_HI;
      fn_q[12] <= LVL_HI;
      fn_q[13] <= LVL_HI;
      fn_q[14] <= LVL_HI;
      fn_q[15] <= LVL_HI;
      fn_q[21] <= LVL_HI;
      fn_q[22] <= LVL_HI;
      fn_q[23] <= LVL_HI;
    end else begin
      fn_q <= fn_d;
    end
  end

  // ==========================================================
  // Pin outputs
  // ==========================================================
  assign general_output_eight_pin      = fn_q[0];
  assign scan_drive_twelve_pin     = fn_q[1];
  assign scan_drive_thirteen_pin     = fn_q[2];
  assign scan_drive_thirteen_pin_oe  = fn_q[3];
  assign gpio17_pin    = fn_q[4];
  assign gpio17_pin_oe = fn_q[5];
  assign gpio8_pin     = fn_q[6];
  assign gpio8_pin_oe  = fn_q[7];
  assign gpio9_pin     = fn_q[8];
  assign gpio9_pin_oe  = fn_q[9];
  assign uart_rxd      = fn_q[10];
  assign general_output_ten_pin     = fn_q[11];
  assign fdd_pin       = fn_q[12];
  assign fdd_pin_oe    = fn_q[13];
  assign mcu_serial_rx = fn_q[14];
  assign pwr_pin       = fn_q[15];
  assign general_output_one_pin      = fn_q[16];
  assign gpio20_pin    = fn_q[17];
  assign gpio20_pin_oe = fn_q[18];
  assign gpio21_pin    = fn_q[19];
  assign gpio21_pin_oe = fn_q[20];
  assign ps2_pullup_en = fn_q[21];
  assign ps2_clk_in    = fn_q[22];
  assign ps2_dat_in    = fn_q[23];

endmodule // gppfm_top

// >>> test/gppfm_top_sva.sv
module gppfm_chk #(
  parameter int unsigned NUM_PAIRS = 4
) (
  input wire logic                 clk,
  input wire logic                 rst_b,
  input wire logic [15:0]          mcu_addr,
  input wire logic                 mcu_wr_en,
  input wire logic [7:0]           mcu_wr_data,
  input wire logic                 mcu_rd_en,
  input wire logic [7:0]           mcu_rd_data,
  input wire logic                 scan13_select,
  input wire logic [NUM_PAIRS-1:0] source_pin,
  input wire logic [NUM_PAIRS-1:0] partner_gpio_out,
  input wire logic [NUM_PAIRS-1:0] partner_gpio_dir,
  input wire logic [NUM_PAIRS-1:0] partner_pin,
  input wire logic [NUM_PAIRS-1:0] partner_pin_oe,
  input wire logic [NUM_PAIRS-1:0] source_level,
  input wire logic                 general_output_eight,
  input wire logic                 keyboard_host_reset,
  input wire logic                 addr_line_gate,
  input wire logic                 scan_drive_thirteen,
  input wire logic                 gpio17_out,
  input wire logic                 gpio18_out,
  input wire logic                 general_output_eight_pin,
  input wire logic                 scan_drive_thirteen_pin,
  input wire logic                 gpio17_pin,
  input wire logic                 ps2_clk_in,
  input wire logic                 ps2_dat_in
);
  import gppfm_pkg::*;
  logic [7:0]           fs_q;
  logic [7:0]           ps_q;
  logic [NUM_PAIRS-1:0] ps;
  assign ps = ps_q[NUM_PAIRS-1:0];
  // ====================
  // Register mirror
  // ====================
  // Routing uses the next value, so pins change at the storing edge, same as this mirror
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) fs_q <= 8'h00;
    else if (mcu_wr_en && mcu_addr == FUNC_SEL1_ADDR) fs_q <= mcu_wr_data & 8'hDF;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) ps_q <= 8'h00;
    else if (mcu_wr_en && mcu_addr == PASS_SEL_ADDR) ps_q <= mcu_wr_data & 8'h0F;
  end
  // ====================
  // Properties
  // ====================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  rd_data_a: assert property (mcu_rd_en |=> mcu_rd_data ==
    ($past(mcu_addr) == FUNC_SEL1_ADDR ? $past(fs_q) :
     $past(mcu_addr) == PASS_SEL_ADDR ? $past(ps_q) : 8'h00))
    else $error("read data wrong");
  rd_hold_a: assert property (!mcu_rd_en |=> $stable(mcu_rd_data))
    else $error("read data moved without read");
  pass_pin_a: assert property ($past(rst_b, 3) |->
    partner_pin == (ps & $past(source_pin, 3) | ~ps & $past(partner_gpio_out)))
    else $error("partner pin level wrong");
  pass_oe_a: assert property ($past(rst_b) |->
    partner_pin_oe == (ps | $past(partner_gpio_dir)))
    else $error("partner pin direction wrong");
  src_level_a: assert property ($past(rst_b, 2) |->
    source_level == $past(source_pin, 2)) else $error("source level wrong");
  general_output_eight_route_a: assert property ($past(rst_b) |-> general_output_eight_pin ==
    (fs_q[GATE_BIT] ? $past(keyboard_host_reset) : $past(general_output_eight)))
    else $error("general_output_eight pin routing wrong");
  scan_drive_thirteen_route_a: assert property ($past(rst_b) |-> scan_drive_thirteen_pin ==
    ($past(scan13_select) ? $past(gpio18_out) : $past(scan_drive_thirteen)))
    else $error("scan 13 pin routing wrong");
  gate_pin_a: assert property ($past(rst_b) |-> gpio17_pin ==
    (fs_q[GATE_BIT] ? $past(addr_line_gate) : $past(gpio17_out)))
    else $error("pin 17 routing wrong");
  ps2_high_a: assert property (!fs_q[PS2_PINS_BIT] |->
    ps2_clk_in && ps2_dat_in) else $error("ps2 inputs not high");
  pass_all_c: cover property (ps_q[3:0] == 4'hF);
  both_route_c: cover property ($past(scan13_select) && fs_q[GATE_BIT]);
  rd_wr_c: cover property (mcu_wr_en && mcu_rd_en);
endmodule // gppfm_chk

bind gppfm_top gppfm_chk #(.NUM_PAIRS(NUM_PAIRS)) u_chk (
  .clk, .rst_b, .mcu_addr, .mcu_wr_en, .mcu_wr_data, .mcu_rd_en,
  .mcu_rd_data, .scan13_select, .source_pin, .partner_gpio_out,
  .partner_gpio_dir, .partner_pin, .partner_pin_oe, .source_level,
  .general_output_eight, .keyboard_host_reset, .addr_line_gate,
  .scan_drive_thirteen, .gpio17_out, .gpio18_out, .general_output_eight_pin, .scan_drive_thirteen_pin,
  .gpio17_pin, .ps2_clk_in, .ps2_dat_in
);

// >>> test/gpio_passthrough_and_pin_function_mux_tb_top.sv
module gpio_passthrough_and_pin_function_mux_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import gppfm_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [15:0] mcu_addr;
  logic [7:0]  mcu_wr_data, mcu_rd_data, fs, prd;
  logic [3:0]  source_pin, partner_gpio_out, partner_gpio_dir;
  logic [3:0]  partner_pin, partner_pin_oe, source_level, ps, h1, h2, h3;
  logic [3:0]  g1, g2, g3;
  logic        mcu_wr_en, mcu_rd_en, scan13_select, pr;
  logic        general_output_eight, keyboard_host_reset, addr_line_gate;
  logic        scan_drive_twelve, scan_drive_thirteen, gpio17_out, gpio17_oe;
  logic        gpio18_out, gpio18_oe, gpio8_out, gpio8_oe, gpio9_out, gpio9_oe;
  logic        uart_txd, gpio8_pin_in, general_output_ten, pwm_zero;
  logic        floppy_led_n, fdd_pin_in, power_led_n, mcu_serial_tx;
  logic        general_output_one, irq_eight_n, gpio20_out, gpio20_oe;
  logic        gpio21_out, gpio21_oe, ps2_chan_en, ps2_clk_drive_low;
  logic        ps2_dat_drive_low, gpio20_pin_in, gpio21_pin_in;
  logic        general_output_eight_pin, scan_drive_twelve_pin, scan_drive_thirteen_pin, scan_drive_thirteen_pin_oe, gpio17_pin;
  logic        gpio17_pin_oe, gpio8_pin, gpio8_pin_oe, gpio9_pin, gpio9_pin_oe;
  logic        uart_rxd, general_output_ten_pin, fdd_pin, fdd_pin_oe, mcu_serial_rx;
  logic        pwr_pin, general_output_one_pin, gpio20_pin, gpio20_pin_oe, gpio21_pin;
  logic        gpio21_pin_oe, ps2_pullup_en, ps2_clk_in, ps2_dat_in;
  integer      seed = 90610;
  int          failures = 0;
  int          n_checks = 0;
  int          nr = 0;
  int          cyc = 0;

  gppfm_top DUT (.*);

  always #10 clk = ~clk;

  // ====================
  // Helpers
  // ====================
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      failures++;
      stop_test();
    end
  end

  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  function automatic logic [3:0] exp_route(input logic sc, input logic g);
    logic o8;
    o8 = g ? keyboard_host_reset : general_output_eight;
    return {o8, sc ? o8 : scan_drive_twelve,
            sc ? gpio18_out : scan_drive_thirteen,
            g ? addr_line_gate : gpio17_out};
  endfunction

  task automatic rand_in();
    logic [31:0] r;
    r = $random(seed);
    {scan13_select, source_pin, partner_gpio_out, partner_gpio_dir} = r[12:0];
    r = $random(seed);
    {general_output_eight, keyboard_host_reset, addr_line_gate,
     scan_drive_twelve, scan_drive_thirteen, gpio17_out, gpio17_oe,
     gpio18_out, gpio18_oe, gpio8_out, gpio8_oe, gpio9_out, gpio9_oe,
     uart_txd, gpio8_pin_in, general_output_ten, pwm_zero, floppy_led_n,
     fdd_pin_in, power_led_n, mcu_serial_tx, general_output_one, irq_eight_n,
     gpio20_out, gpio20_oe, gpio21_out, gpio21_oe, ps2_chan_en,
     ps2_clk_drive_low, ps2_dat_drive_low, gpio20_pin_in, gpio21_pin_in} = r;
  endtask

  task automatic do_reset();
    @(negedge clk);
    rst_b = 1'b0;
    {fs, ps, pr, nr} = '0;
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
  endtask

  // Checks what the last edge produced, then drives the next cycle
  task automatic tick(input logic we, input logic re, input logic [15:0] a,
                      input logic [7:0] d);
    logic [3:0] e;
    @(negedge clk);
    nr++;
    {h3, h2, h1} = {h2, h1, source_pin};
    {g3, g2, g1} = {g2, g1, gpio21_pin_in, gpio20_pin_in, fdd_pin_in,
                    gpio8_pin_in};
    if (pr)
      chk("rd_data", mcu_rd_data, prd);
    // Synchronised pad paths are settled only three cycles after reset
    if (nr > 3) begin
      e = ps & h3 | ~ps & partner_gpio_out;
      chk("partner", partner_pin, e);
      chk("src_level", source_level, h2);
      e = {fs[7] ? g3[0] : 1'b1, fs[3] ? g3[1] : 1'b1, 2'b11};
      if (fs[1] && ps2_chan_en) e[1:0] = {g3[2], g3[3]};
      chk("rx_in", {uart_rxd, mcu_serial_rx}, e[3:2]);
      chk("ps2_rx", {ps2_clk_in, ps2_dat_in}, e[1:0]);
    end
    chk("dir", partner_pin_oe, ps | partner_gpio_dir);
    e = exp_route(scan13_select, fs[6]);
    chk("route", {general_output_eight_pin, scan_drive_twelve_pin, scan_drive_thirteen_pin, gpio17_pin}, e);
    chk("general_output_ten", general_output_ten_pin, fs[4] ? pwm_zero : general_output_ten);
    chk("pwr", pwr_pin, fs[2] ? mcu_serial_tx : power_led_n);
    chk("general_output_one", general_output_one_pin, fs[0] ? irq_eight_n : general_output_one);
    chk("txd", gpio9_pin, fs[7] ? uart_txd : gpio9_out);
    chk("rxd_oe", gpio8_pin_oe, fs[7] ? 1'b0 : gpio8_oe);
    chk("fdd_rx", fs[3] ? fdd_pin_oe : mcu_serial_rx, !fs[3]);
    chk("pad20", gpio20_pin, fs[1] ? 1'b0 : gpio20_out);
    chk("oe20", gpio20_pin_oe, fs[1] ? ps2_clk_drive_low : gpio20_oe);
    e = {scan13_select ? gpio18_oe : 1'b1, fs[6] | gpio17_oe,
         fs[7] ? 2'b01 : {gpio8_out, gpio9_oe}};
    chk("sh_oe", {scan_drive_thirteen_pin_oe, gpio17_pin_oe}, e[3:2]);
    chk("ser", {gpio8_pin, gpio9_pin_oe}, e[1:0]);
    e = {fs[3] ? 2'b00 : {floppy_led_n, 1'b1},
         fs[1] ? {1'b0, ps2_dat_drive_low} : {gpio21_out, gpio21_oe}};
    chk("fdd", {fdd_pin, fdd_pin_oe}, e[3:2]);
    chk("pad21", {gpio21_pin, gpio21_pin_oe}, e[1:0]);
    chk("pullup", ps2_pullup_en, !(fs[1] && ps2_chan_en));
    if (!(fs[1] && ps2_chan_en))
      chk("ps2_in", {ps2_clk_in, ps2_dat_in}, 2'b11);
    prd = a == FUNC_SEL1_ADDR ? fs : a == PASS_SEL_ADDR ? {4'h0, ps} : 8'h00;
    pr = re;
    if (we && a == FUNC_SEL1_ADDR) fs = d & 8'hDF;
    if (we && a == PASS_SEL_ADDR) ps = d[3:0];
    {mcu_wr_en, mcu_rd_en, mcu_addr, mcu_wr_data} = {we, re, a, d};
    rand_in();
  endtask

  // ====================
  // Scenarios
  // ====================
  initial begin
    logic [31:0] r;
    {mcu_wr_en, mcu_rd_en, mcu_addr, mcu_wr_data} = '0;
    {h1, h2, h3, g1, g2, g3, prd} = '0;
    rand_in();
    do_reset();
    tick(1'b0, 1'b1, FUNC_SEL1_ADDR, 8'h00);
    tick(1'b0, 1'b1, PASS_SEL_ADDR, 8'h00);
    tick(1'b1, 1'b0, FUNC_SEL1_ADDR, 8'hFF);
    tick(1'b1, 1'b1, PASS_SEL_ADDR, 8'hFF);
    tick(1'b0, 1'b1, FUNC_SEL1_ADDR, 8'h00);
    tick(1'b0, 1'b1, PASS_SEL_ADDR, 8'h00);
    tick(1'b1, 1'b1, 16'h7F40, 8'hFF);
    tick(1'b1, 1'b1, 16'h7F3E, 8'hFF);
    tick(1'b0, 1'b0, 16'h0000, 8'h00);
    do_reset();
    tick(1'b0, 1'b1, FUNC_SEL1_ADDR, 8'h00);
    tick(1'b0, 1'b1, PASS_SEL_ADDR, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 16; i++) begin
      tick(1'b1, 1'b0, PASS_SEL_ADDR, {4'hA, 4'(i)});
      tick(1'b0, 1'b1, PASS_SEL_ADDR, 8'h00);
      repeat (5) tick(1'b0, 1'b0, 16'h0000, 8'h00);
    end
    $display("test pass-through done");
    for (int i = 0; i < 48; i++) begin
      r = $random(seed);
      tick(1'b1, r[8], FUNC_SEL1_ADDR, i < 2 ? {8{i[0]}} : r[7:0]);
      repeat (3) tick(1'b0, 1'b0, 16'h0000, 8'h00);
    end
    $display("test pin functions done");
    stop_test();
  end
endmodule // gpio_passthrough_and_pin_function_mux_tb_top
